// File: gis_ctrl.sv
// global interrupt status and control register with interrupt steering
// assumes one clock, local register port at pci side, pins from outside
//
// Summary of operation
// - bit 0 reads live uart 0 interrupt
// - bit 1 reads live uart 1 interrupt
// - bits 2,3 read pin internal levels
// - bit 16 gates uart 0 onto function 0
// - bit 17 gates uart 1 onto function 0
// - bit 18 enables pin 0 interrupt
// - bit 19 enables pin 1 interrupt
// - pins active high unless inversion configured
// - bit 20 lets pin 0 set power-down sticky
// - function 0 power-down needs filtered agreement
// - function 1 power-down is immediate, unfiltered
// - bits 26,27 route pins to function
// - bits 22,23 sticky, cleared on read
// - pin config: noninv, inv, drive 0, 1
`timescale 1ns/1ps
`include "gis_defines.svh"

module gis_ctrl
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire gis_pkg::gis_reg_req_t reg_req,
  input  wire gis_pkg::gis_src_t    src,
  input  wire logic [1:0]           general_pin_in,
  output logic [1:0]                general_pin_out,
  output logic [1:0]                general_pin_oe,
  output logic [31:0]               reg_rdata,
  output logic                      reg_rvalid,
  output logic                      pci_irq_f0,
  output logic                      pci_irq_f1
);

  localparam logic [10:0] FILT_LAST = 11'(`GIS_FILTER_CYCLES - 1);

  gis_pkg::gis_state_t st_q;
  gis_pkg::gis_state_t st_d;

  logic [1:0] pin_int;
  logic [1:0] pin_act;
  logic       sel;
  logic       pin0_pd_f0;
  logic       filt_cond;
  logic       f1_pd_req;
  logic       f0_irq_src;
  logic       f1_irq_src;

  // true when the field selects an inverting input
  function automatic logic cfg_inverts(input logic [1:0] cfg);
    cfg_inverts = (cfg == `GIS_CFG_INV_IN);
  endfunction

  // true when the field selects an input pin
  function automatic logic cfg_is_input(input logic [1:0] cfg);
    cfg_is_input = ~cfg[`GIS_CFG_DIR_BIT];
  endfunction

  // per-pin internal level and active source
  // inversion decode
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_pin
      assign pin_int[i] = st_q.sync2[i] ^ cfg_inverts(src.general_pin_config[2*i +: 2]);
      // output pins never raise interrupts of their own
      assign pin_act[i] = pin_int[i] & cfg_is_input(src.general_pin_config[2*i +: 2]);
    end
  endgenerate

  assign sel = reg_req.addr == `GIS_REG_OFFSET;

  // power-down sources
  // pin 0 power-down routing
  assign pin0_pd_f0 = st_q.pin0_pd_en & ~st_q.route[0];
  assign f1_pd_req  = st_q.pin0_pd_en & st_q.route[0] & pin_act[0];
  // pin 0 joins the filter only when routed to function 0
  assign filt_cond  = src.uart0_pd & src.uart1_pd & (~pin0_pd_f0 | pin_act[0]);

  // interrupt steering
  // OR of sources
  assign f0_irq_src = (src.uart0_irq & st_q.uart_mask[0])
                    | (src.uart1_irq & st_q.uart_mask[1])
                    | (pin_act[0] & st_q.pin_mask[0] & ~st_q.route[0])
                    | (pin_act[1] & st_q.pin_mask[1] & ~st_q.route[1]);
  assign f1_irq_src = (pin_act[0] & st_q.pin_mask[0] & st_q.route[0])
                    | (pin_act[1] & st_q.pin_mask[1] & st_q.route[1]);

  // next state
  always_comb
  begin
    st_d = st_q;
    // two-stage pin synchroniser; first stage feeds only the second
    st_d.sync1 = general_pin_in;
    st_d.sync2 = st_q.sync1;
    st_d.irq_f0 = f0_irq_src;
    st_d.irq_f1 = f1_irq_src;
    st_d.pin_oe  = {src.general_pin_config[3], src.general_pin_config[1]};
    st_d.pin_out = {src.general_pin_config[2], src.general_pin_config[0]};
    st_d.f0_pd_req = 1'h0;

    case (st_q.filt)
      gis_pkg::GIS_FILT_IDLE:
      begin
        st_d.filt_cnt = 11'h000;
        if (filt_cond)
        begin
          st_d.filt = gis_pkg::GIS_FILT_COUNT;
        end
      end
      gis_pkg::GIS_FILT_COUNT:
      begin
        if (!filt_cond)
        begin
          st_d.filt = gis_pkg::GIS_FILT_IDLE;
        end
        else if (st_q.filt_cnt == FILT_LAST)
        begin
          st_d.f0_pd_req = 1'h1;
          st_d.filt      = gis_pkg::GIS_FILT_DONE;
        end
        else
        begin
          st_d.filt_cnt = st_q.filt_cnt + 11'h001;
        end
      end
      gis_pkg::GIS_FILT_DONE:
      begin
        // one request per episode; must drop out before another
        if (!filt_cond)
        begin
          st_d.filt = gis_pkg::GIS_FILT_IDLE;
        end
      end
      default:
      begin
        st_d.filt = gis_pkg::GIS_FILT_IDLE;
      end
    endcase

    // register read, data shows state sampled at the request
    st_d.rvalid = reg_req.rd;
    st_d.rdata  = 32'h0000_0000;
    if (reg_req.rd && sel)
    begin
      st_d.rdata[`GIS_BIT_UART0_IRQ]  = src.uart0_irq;
      st_d.rdata[`GIS_BIT_UART1_IRQ]  = src.uart1_irq;
      st_d.rdata[`GIS_BIT_PIN0_INT]   = pin_int[0];
      st_d.rdata[`GIS_BIT_PIN1_INT]   = pin_int[1];
      st_d.rdata[`GIS_BIT_UART0_MASK] = st_q.uart_mask[0];
      st_d.rdata[`GIS_BIT_UART1_MASK] = st_q.uart_mask[1];
      st_d.rdata[`GIS_BIT_PIN0_MASK]  = st_q.pin_mask[0];
      st_d.rdata[`GIS_BIT_PIN1_MASK]  = st_q.pin_mask[1];
      st_d.rdata[`GIS_BIT_PIN0_PD_EN] = st_q.pin0_pd_en;
      st_d.rdata[`GIS_BIT_F0_PD_STS]  = st_q.pd_sticky[0];
      st_d.rdata[`GIS_BIT_F1_PD_STS]  = st_q.pd_sticky[1];
      st_d.rdata[`GIS_BIT_PIN0_ROUTE] = st_q.route[0];
      st_d.rdata[`GIS_BIT_PIN1_ROUTE] = st_q.route[1];
      st_d.pd_sticky = 2'h0;
    end

    // writable fields; status bits ignore writes
    if (reg_req.wr && sel)
    begin
      st_d.uart_mask  = {reg_req.wdata[`GIS_BIT_UART1_MASK], reg_req.wdata[`GIS_BIT_UART0_MASK]};
      st_d.pin_mask   = {reg_req.wdata[`GIS_BIT_PIN1_MASK], reg_req.wdata[`GIS_BIT_PIN0_MASK]};
      st_d.pin0_pd_en = reg_req.wdata[`GIS_BIT_PIN0_PD_EN];
      st_d.route = {reg_req.wdata[`GIS_BIT_PIN1_ROUTE], reg_req.wdata[`GIS_BIT_PIN0_ROUTE]};
    end

    // a request in the clearing cycle still sets
    if (st_q.f0_pd_req)
    begin
      st_d.pd_sticky[0] = 1'h1;
    end
    if (f1_pd_req)
    begin
      st_d.pd_sticky[1] = 1'h1;
    end
  end

  // state register, constants only under reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q            <= '0;
      st_q.uart_mask  <= {2{`GIS_RST_UART_MASK}};
      st_q.pin_mask   <= {2{`GIS_RST_PIN_MASK}};
      st_q.pin0_pd_en <= `GIS_RST_PD_EN;
      st_q.route      <= {2{`GIS_RST_ROUTE}};
      st_q.pd_sticky  <= {2{`GIS_RST_STICKY}};
      st_q.filt       <= gis_pkg::GIS_FILT_IDLE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign general_pin_out = st_q.pin_out;
  assign general_pin_oe  = st_q.pin_oe;
  assign reg_rdata       = st_q.rdata;
  assign reg_rvalid      = st_q.rvalid;
  assign pci_irq_f0      = st_q.irq_f0;
  assign pci_irq_f1      = st_q.irq_f1;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_UART0_STATUS: assert property (
    reg_req.rd && sel |=> reg_rdata[0] == $past(src.uart0_irq))
    else $error("uart 0 status bit wrong");

  AST_UART1_STATUS: assert property (
    reg_req.rd && sel |=> reg_rdata[1] == $past(src.uart1_irq))
    else $error("uart 1 status bit wrong");

  AST_PIN_STATE: assert property (
    reg_req.rd && sel && src.general_pin_config[1:0] == 2'h1
    ##0 $stable(src.general_pin_config) [*1] |=> reg_rdata[2] == ~$past(st_q.sync2[0]))
    else $error("pin 0 internal state wrong");

  AST_UART0_GATE: assert property (
    src.uart0_irq && st_q.uart_mask[0] |=> pci_irq_f0)
    else $error("enabled uart 0 did not raise function 0");

  AST_UART1_BLOCK: assert property (
    !st_q.uart_mask[1] && !src.uart0_irq && pin_act == 2'h0 |=> !pci_irq_f0)
    else $error("blocked uart 1 raised function 0");

  AST_PIN0_ROUTE: assert property (
    pin_act[0] && st_q.pin_mask[0] && st_q.route[0] |=> pci_irq_f1)
    else $error("pin 0 did not raise function 1");

  AST_PIN1_MASKED: assert property (
    !st_q.pin_mask[1] && !(pin_act[0] && st_q.pin_mask[0] && st_q.route[0]) |=> !pci_irq_f1)
    else $error("masked pin 1 raised function 1");

  AST_PIN1_TO_F0: assert property (
    pin_act[1] && st_q.pin_mask[1] && !st_q.route[1] |=> pci_irq_f0)
    else $error("pin 1 did not raise function 0");

  AST_F1_IMMEDIATE: assert property (
    st_q.pin0_pd_en && st_q.route[0] && pin_act[0] |=> st_q.pd_sticky[1])
    else $error("function 1 power-down not immediate");

  AST_FILTER_HOLD: assert property (
    st_q.f0_pd_req |-> $past(filt_cond) && $past(st_q.filt_cnt) == FILT_LAST)
    else $error("function 0 power-down before filter period");

  AST_FILTER_BREAK: assert property (
    st_q.filt == gis_pkg::GIS_FILT_COUNT && !filt_cond
    |=> st_q.filt == gis_pkg::GIS_FILT_IDLE && !st_q.f0_pd_req)
    else $error("filter kept counting without agreement");

  AST_F0_STICKY: assert property (
    st_q.f0_pd_req |=> st_q.pd_sticky[0])
    else $error("function 0 sticky bit not set");

  AST_STICKY_CLEAR: assert property (
    reg_req.rd && sel && !st_q.f0_pd_req |=> !st_q.pd_sticky[0])
    else $error("sticky bit not cleared on read");

  AST_PIN_DRIVE: assert property (
    src.general_pin_config[1:0] == 2'h3 |=> general_pin_oe[0] && general_pin_out[0])
    else $error("pin 0 not driving one");

  AST_PIN_INPUT_QUIET: assert property (
    !src.general_pin_config[1] |=> !general_pin_oe[0])
    else $error("input pin 0 driven");

  // main scenarios
  COV_F0_PD: cover property (st_q.f0_pd_req);
  COV_F1_IRQ: cover property (pci_irq_f1);
  COV_CLEAR_RACE: cover property (reg_req.rd && sel && st_q.f0_pd_req);
  COV_PIN1_F0: cover property (pin_act[1] && st_q.pin_mask[1] && !st_q.route[1]);
  COV_FILTER_BREAK: cover property (st_q.filt == gis_pkg::GIS_FILT_COUNT && !filt_cond);

endmodule

// File: gis_defines.svh
// register offset, field positions, reset values and timing counts for the
// global interrupt status and control block; definitions only
`ifndef GIS_DEFINES_SVH
`define GIS_DEFINES_SVH

`define GIS_REG_OFFSET      8'h10
`define GIS_BIT_UART0_IRQ   0
`define GIS_BIT_UART1_IRQ   1
`define GIS_BIT_PIN0_INT    2
`define GIS_BIT_PIN1_INT    3
`define GIS_BIT_UART0_MASK  16
`define GIS_BIT_UART1_MASK  17
`define GIS_BIT_PIN0_MASK   18
`define GIS_BIT_PIN1_MASK   19
`define GIS_BIT_PIN0_PD_EN  20
`define GIS_BIT_F0_PD_STS   22
`define GIS_BIT_F1_PD_STS   23
`define GIS_BIT_PIN0_ROUTE  26
`define GIS_BIT_PIN1_ROUTE  27

`define GIS_RST_UART_MASK   1'h1
`define GIS_RST_PIN_MASK    1'h0
`define GIS_RST_PD_EN       1'h0
`define GIS_RST_ROUTE       1'h1
`define GIS_RST_STICKY      1'h0

// pin configuration field codes
`define GIS_CFG_INV_IN      2'h1
`define GIS_CFG_DIR_BIT     1

// power-down filter period
`define GIS_CLK_MHZ         10
`define GIS_FILTER_TIME_US  100
`define GIS_FILTER_CYCLES   (`GIS_FILTER_TIME_US * `GIS_CLK_MHZ)

`endif

// File: gis_pkg.sv
// types shared by the global interrupt status and control block
// assumes gis_defines.svh supplies the numeric constants
package gis_pkg;

  // power-down filter states
  typedef enum logic [1:0]
  {
    GIS_FILT_IDLE  = 2'b00,
    GIS_FILT_COUNT = 2'b01,
    GIS_FILT_DONE  = 2'b10
  } gis_filt_state_t;

  // local register request
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } gis_reg_req_t;

  // sources inside the device, same clock
  typedef struct packed
  {
    logic       uart0_irq;
    logic       uart1_irq;
    logic       uart0_pd;
    logic       uart1_pd;
    logic [3:0] general_pin_config;
  } gis_src_t;

  // whole module state
  typedef struct packed
  {
    logic [1:0]      sync1;
    logic [1:0]      sync2;
    logic [1:0]      uart_mask;
    logic [1:0]      pin_mask;
    logic            pin0_pd_en;
    logic [1:0]      route;
    logic [1:0]      pd_sticky;
    gis_filt_state_t filt;
    logic [10:0]     filt_cnt;
    logic            f0_pd_req;
    logic            irq_f0;
    logic            irq_f1;
    logic [1:0]      pin_oe;
    logic [1:0]      pin_out;
    logic [31:0]     rdata;
    logic            rvalid;
  } gis_state_t;

endpackage

// File: gis_src_model.sv
// stand-in for the internal uart interrupt and power-down sources
// assumes the bench changes the levels away from the rising edge
`timescale 1ns/1ps

module gis_src_model
(
  input  wire logic [1:0] irq_lvl,
  input  wire logic [1:0] pd_lvl,
  input  wire logic [3:0] cfg,
  output wire gis_pkg::gis_src_t src
);
  // plain levels, no handshake: real uart lines are levels too
  assign src.uart0_irq          = irq_lvl[0];
  assign src.uart1_irq          = irq_lvl[1];
  assign src.uart0_pd           = pd_lvl[0];
  assign src.uart1_pd           = pd_lvl[1];
  assign src.general_pin_config = cfg;
endmodule

// File: testbench.sv
// self-checking bench for the global interrupt status and control block
// assumes gis_ctrl, gis_src_model and the shared package are compiled
`timescale 1ns/1ps

module testbench;
  logic                  clk;
  logic                  rst_b;
  gis_pkg::gis_reg_req_t req;
  gis_pkg::gis_src_t     src;
  logic [1:0]            uirq, upd, pin, pout, poe;
  logic [3:0]            cfg;
  logic [31:0]           ctl, rdata;
  logic [31:0]           exp_q[$];
  logic                  rvalid, irq0, irq1;
  int                    num_errors, num_checks;

  gis_src_model u_src (.irq_lvl(uirq), .pd_lvl(upd), .cfg(cfg), .src(src));

  gis_ctrl u_dut
  (
    .clk(clk), .rst_b(rst_b), .reg_req(req), .src(src), .general_pin_in(pin),
    .general_pin_out(pout), .general_pin_oe(poe), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .pci_irq_f0(irq0), .pci_irq_f1(irq1)
  );

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    // a read that never answered leaves its note behind
    cmp("pending_reads", 32'h0, 32'(exp_q.size()));
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  // expected word: live sources, written controls, sticky bits
  function automatic logic [31:0] ev(logic [1:0] stk);
    ev = ctl | {8'h0, stk, 22'h0} | {28'h0, pin ^ {cfg[2], cfg[0]}, uirq};
  endfunction

  // one-cycle strobes, driven at the falling edge; an idle cycle after
  // each keeps back-to-back calls from lowering and raising at once
  task automatic wr(logic [7:0] a, logic [31:0] d);
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    cyc(1);
    req.wr    = 1'b0;
    cyc(1);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    req.addr = a;
    req.rd   = 1'b1;
    cyc(1);
    req.rd   = 1'b0;
    cyc(1);
  endtask

  task automatic chk_irq();
    logic [1:0] act;
    logic       f0, f1;
    act = (pin ^ {cfg[2], cfg[0]}) & ctl[19:18];
    f0  = |(uirq & ctl[17:16]) | |(act & ~ctl[27:26]);
    f1  = |(act & ctl[27:26]);
    cmp("irq_f0", {31'h0, f0}, {31'h0, irq0});
    cmp("irq_f1", {31'h0, f1}, {31'h0, irq1});
  endtask

  // read monitor: oldest note against each answer
  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp("rvalid", 32'h0, 32'h1);
      else
        cmp("rdata", exp_q.pop_front(), rdata);
    end
  end

  // hang guard, well above the ~1350 cycles used
  initial
  begin
    cyc(5000);
    num_errors++;
    end_sim();
  end

  initial
  begin
    rst_b = 1'b0;
    req   = '0;
    uirq  = 2'h0;
    upd   = 2'h0;
    pin   = 2'h0;
    cfg   = 4'h0;
    ctl   = 32'h0c030000;
    void'($urandom(79));
    cyc(20);
    rst_b = 1'b1;
    cyc(2);
    rd(8'h10, ev(2'h0));
    // random masks, routes, polarities; junk in read-only bits
    repeat (24)
    begin
      uirq = 2'($urandom);
      pin  = 2'($urandom);
      cfg  = 4'($urandom) & 4'h5;
      ctl  = $urandom & 32'h0c0f0000;
      wr(8'h10, ctl | ($urandom & 32'hf3e0ffff));
      cyc(4);
      chk_irq();
      rd(8'h10, ev(2'h0));
    end
    // unmapped offset: write ignored, read gives zero
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    rd(8'h10, ev(2'h0));
    // output modes drive the pins
    cfg = 4'hb;
    cyc(3);
    cmp("pin_oe", 32'h3, {30'h0, poe});
    cmp("pin_out", 32'h1, {30'h0, pout});
    // function 1 power-down: immediate, sticky until read
    cfg = 4'h0;
    ctl = 32'h0c100000;
    wr(8'h10, ctl);
    pin = 2'h1;
    cyc(4);
    pin = 2'h0;
    cyc(4);
    rd(8'h10, ev(2'h2));
    rd(8'h10, ev(2'h0));
    // function 0 power-down only after the full filter period
    ctl = 32'h08100000;
    wr(8'h10, ctl);
    upd = 2'h3;
    pin = 2'h1;
    cyc(900);
    rd(8'h10, ev(2'h0));
    cyc(200);
    rd(8'h10, ev(2'h1));
    rd(8'h10, ev(2'h0));
    upd = 2'h0;
    cyc(4);
    end_sim();
  end
endmodule
